// ==== logic/lbm_pkg.sv ====
//----------------------------------------------------------------
// How it works
//----------------------------------------------------------------
// How it works
// - Each 128 ms cycle with fault adds one
// - Clean run of 1/2/4/8 cycles leaks one
// - Rate code 00..11 picks 128..1024 ms leak
// - Alarm rises when count reaches upper threshold
// - Alarm clears when count falls to lower threshold
// - Count saturates at bucket size limit
package lbm_pkg;

	typedef logic [7:0] lbm_byte_t;
	typedef logic [1:0] lbm_rate_t;

	//----------------------------------------------------------------
	// Timing
	//----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MON_CYCLE_MS  = 128;
	localparam int unsigned MON_CYCLE_CLKS = MON_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned RUN_W         = 4;

	//----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	//----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 12;
	localparam logic [9:0]  IDX_LEAK_RATE   = 10'h057;
	localparam logic [9:0]  IDX_RAISE_LEVEL = 10'h058;
	localparam logic [9:0]  IDX_CLEAR_LEVEL = 10'h059;
	localparam logic [9:0]  IDX_BUCKET_SIZE = 10'h05a;
	localparam logic [9:0]  IDX_STATUS      = 10'h060;

	//----------------------------------------------------------------
	// Field layout and reset values
	//----------------------------------------------------------------
	localparam int unsigned RATE_LSB      = 0;
	localparam int unsigned RATE_MSB      = 1;
	localparam int unsigned STAT_ALARM    = 8;
	localparam lbm_rate_t   RST_LEAK_RATE = 2'h2;
	localparam lbm_byte_t   RST_RAISE     = 8'h06;
	localparam lbm_byte_t   RST_CLEAR     = 8'h04;
	localparam lbm_byte_t   RST_SIZE      = 8'h08;

	// Clean cycles that make up one leak for a rate code
	function automatic logic [RUN_W-1:0] leakRuns(input lbm_rate_t rate);
		leakRuns = 4'h1 << rate;
	endfunction : leakRuns

	function automatic logic [ADDR_W-1:0] regAddr(input logic [9:0] idx);
		regAddr = {idx, 2'h0};
	endfunction : regAddr

endpackage : lbm_pkg

// ==== logic/lbm_cycle_tick.sv ====
`timescale 1ns/100ps
module lbm_cycle_tick #(
	parameter int unsigned DIV = lbm_pkg::MON_CYCLE_CLKS
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// One-cycle pulse at the end of each monitoring cycle
	output logic      tick
);

	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] divCount;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			divCount <= '0;
			tick     <= 1'b0;
		end else if (divCount == LAST) begin
			divCount <= '0;
			tick     <= 1'b1;
		end else begin
			divCount <= divCount + 1'b1;
			tick     <= 1'b0;
		end
	end

endmodule : lbm_cycle_tick

// ==== logic/lbm_leak_timer.sv ====
`timescale 1ns/100ps
module lbm_leak_timer (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Monitoring cycle outcome
	input  wire logic             tick,
	input  wire logic             cycleFault,
	input  wire lbm_pkg::lbm_rate_t rate,
	// Leak request, valid with tick
	output logic                  leak
);

	logic [lbm_pkg::RUN_W-1:0] cleanRun;
	logic                      runDone;

	// A run completes on the clean cycle that brings it to the selected length
	assign runDone = (cleanRun + 1'b1) >= lbm_pkg::leakRuns(rate);
	assign leak    = tick && !cycleFault && runDone;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cleanRun <= '0;
		end else if (tick) begin
			// A faulty cycle breaks the run
			if (cycleFault || runDone) begin
				cleanRun <= '0;
			end else begin
				cleanRun <= cleanRun + 1'b1;
			end
		end
	end

endmodule : lbm_leak_timer

// ==== logic/lbm_activity_monitor.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module lbm_activity_monitor #(
	parameter int unsigned MON_CYCLE_CLKS = lbm_pkg::MON_CYCLE_CLKS
) (
	// Clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [lbm_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Monitored reference: high while failed or erratic
	input  wire logic                        refFault,
	// Status
	output logic                             inactivityAlarm,
	output lbm_pkg::lbm_byte_t               bucketCount
);

	//----------------------------------------------------------------
	// Configuration registers
	//----------------------------------------------------------------
	lbm_pkg::lbm_rate_t leakRate;
	lbm_pkg::lbm_byte_t raiseLevel;
	lbm_pkg::lbm_byte_t clearLevel;
	lbm_pkg::lbm_byte_t bucketSize;

	logic setupPhase;
	logic hitLeak;
	logic hitRaise;
	logic hitClear;
	logic hitSize;
	logic hitStatus;
	logic mapped;
	logic [31:0] next_prdata;

	assign setupPhase = psel && !penable;
	assign hitLeak    = paddr == lbm_pkg::regAddr(lbm_pkg::IDX_LEAK_RATE);
	assign hitRaise   = paddr == lbm_pkg::regAddr(lbm_pkg::IDX_RAISE_LEVEL);
	assign hitClear   = paddr == lbm_pkg::regAddr(lbm_pkg::IDX_CLEAR_LEVEL);
	assign hitSize    = paddr == lbm_pkg::regAddr(lbm_pkg::IDX_BUCKET_SIZE);
	assign hitStatus  = paddr == lbm_pkg::regAddr(lbm_pkg::IDX_STATUS);
	assign mapped     = hitLeak || hitRaise || hitClear || hitSize || hitStatus;

	always_comb begin
		next_prdata = '0;
		if (hitLeak) begin
			// Upper thirty bits of the rate register read as zero
			next_prdata[lbm_pkg::RATE_MSB:lbm_pkg::RATE_LSB] = leakRate;
		end else if (hitRaise) begin
			next_prdata[7:0] = raiseLevel;
		end else if (hitClear) begin
			next_prdata[7:0] = clearLevel;
		end else if (hitSize) begin
			next_prdata[7:0] = bucketSize;
		end else if (hitStatus) begin
			next_prdata[7:0]                 = bucketCount;
			next_prdata[lbm_pkg::STAT_ALARM] = inactivityAlarm;
		end
	end

	// Every transfer finishes in the first access cycle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setupPhase;
			pslverr <= setupPhase && !mapped;
			prdata  <= (setupPhase && !pwrite) ? next_prdata : '0;
		end
	end

	// Writes land at the edge that ends the access phase
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			leakRate   <= lbm_pkg::RST_LEAK_RATE;
			raiseLevel <= lbm_pkg::RST_RAISE;
			clearLevel <= lbm_pkg::RST_CLEAR;
			bucketSize <= lbm_pkg::RST_SIZE;
		end else if (psel && penable && pready && pwrite) begin
			if (hitLeak) begin
				leakRate <= pwdata[lbm_pkg::RATE_MSB:lbm_pkg::RATE_LSB];
			end
			if (hitRaise) begin
				raiseLevel <= pwdata[7:0];
			end
			if (hitClear) begin
				clearLevel <= pwdata[7:0];
			end
			if (hitSize) begin
				bucketSize <= pwdata[7:0];
			end
		end
	end

	//----------------------------------------------------------------
	// Monitoring cycle
	//----------------------------------------------------------------
	logic tick;
	logic leak;
	logic faultSeen;
	logic cycleFault;

	lbm_cycle_tick #(
		.DIV (MON_CYCLE_CLKS)
	) u_tick (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tick    (tick)
	);

	// A fault in the closing cycle still counts for this cycle
	assign cycleFault = faultSeen || refFault;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			faultSeen <= 1'b0;
		end else if (tick) begin
			faultSeen <= 1'b0;
		end else if (refFault) begin
			faultSeen <= 1'b1;
		end
	end

	lbm_leak_timer u_leak (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.tick       (tick),
		.cycleFault (cycleFault),
		.rate       (leakRate),
		.leak       (leak)
	);

	//----------------------------------------------------------------
	// Accumulator and alarm
	//----------------------------------------------------------------
	lbm_pkg::lbm_byte_t next_count;
	logic               next_alarm;

	always_comb begin
		next_count = bucketCount;
		if (tick && cycleFault) begin
			// Held at the size limit; a lowered limit never pulls it down
			if (bucketCount < bucketSize) begin
				next_count = bucketCount + 8'h01;
			end
		end else if (leak && bucketCount != 8'h00) begin
			next_count = bucketCount - 8'h01;
		end
	end

	always_comb begin
		next_alarm = inactivityAlarm;
		// Raise wins when both levels are met, e.g. with overlapping settings
		if (next_count >= raiseLevel) begin
			next_alarm = 1'b1;
		end else if (next_count <= clearLevel) begin
			next_alarm = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bucketCount <= '0;
		end else if (tick) begin
			bucketCount <= next_count;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			inactivityAlarm <= 1'b0;
		end else if (tick) begin
			inactivityAlarm <= next_alarm;
		end
	end

	//----------------------------------------------------------------
	// Checks
	//----------------------------------------------------------------
	logic [lbm_pkg::RUN_W-1:0] helpRun;

	// Clean cycles since the last leak or fault, kept apart from the timer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			helpRun <= '0;
		end else if (tick) begin
			helpRun <= (cycleFault || leak) ? '0 : helpRun + 1'b1;
		end
	end

	sequence faultCycle_s;
		tick && cycleFault;
	endsequence

	sequence leakCycle_s;
		leak;
	endsequence

	default clocking cb @(posedge clk_sys);
	endclocking

	default disable iff (!rstn);

	fault_increment_a: assert property (
		faultCycle_s ##0 (bucketCount < bucketSize) |=> bucketCount == $past(bucketCount) + 8'h01
	) else $error("fault cycle did not add one");

	count_quiet_a: assert property (
		!tick |=> $stable(bucketCount) && $stable(inactivityAlarm)
	) else $error("count moved outside a cycle end");

	leak_step_a: assert property (
		leakCycle_s ##0 (bucketCount != 8'h00) |=> bucketCount == $past(bucketCount) - 8'h01
	) else $error("leak did not take one");

	leak_rate_a: assert property (
		leak |-> (helpRun + 1'b1) == lbm_pkg::leakRuns(leakRate)
	) else $error("leak after wrong number of clean cycles");

	alarm_raise_a: assert property (
		tick ##1 (bucketCount >= raiseLevel) && $stable(raiseLevel) |-> inactivityAlarm
	) else $error("alarm not raised at upper level");

	alarm_clear_a: assert property (
		tick ##1 (bucketCount <= clearLevel) && (bucketCount < raiseLevel)
			&& $stable(clearLevel) && $stable(raiseLevel) |-> !inactivityAlarm
	) else $error("alarm not cleared at lower level");

	size_hold_a: assert property (
		faultCycle_s ##0 (bucketCount >= bucketSize) |=> $stable(bucketCount)
	) else $error("count grew past size limit");

	zero_floor_a: assert property (
		leakCycle_s ##0 (bucketCount == 8'h00) |=> bucketCount == 8'h00
	) else $error("count leaked below zero");

	apb_answer_a: assert property (
		psel && !penable |=> pready ##1 !pready
	) else $error("apb answer not one cycle after setup");

endmodule : lbm_activity_monitor

// ==== test/lbm_ref_source.sv ====
`timescale 1ns/100ps
//----------------------------------------------------------------
// Monitored reference source
//----------------------------------------------------------------
// Steady failure while faultOn is high, a one-clock erratic burst per
// glitch request; both change only just after a rising edge.
module lbm_ref_source (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Commands from the bench
	input  wire logic faultOn,
	input  wire logic glitch,
	// Fault indication towards the monitor
	output logic      refFault
);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			refFault <= 1'b0;
		end else begin
			refFault <= faultOn | glitch;
		end
	end
endmodule : lbm_ref_source

// ==== test/tb.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %0t got %0h want %0h", $time, (a), (e)); end end
module tb;
	localparam int CYC = 8;
	logic               clk_sys = 1'b0;
	logic               rstn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [11:0]        paddr = 12'h000;
	logic [31:0]        pwdata = 32'h0000_0000;
	logic               faultOn = 1'b0;
	logic               glitch = 1'b0;
	wire logic [31:0]   prdata;
	wire logic          pready;
	wire logic          pslverr;
	wire logic          refFault;
	wire logic          inactivityAlarm;
	lbm_pkg::lbm_byte_t bucketCount;
	int                 fail_count = 0;
	int                 n_checks = 0;
	int                 k;

	always #5 clk_sys = ~clk_sys;

	lbm_activity_monitor #(.MON_CYCLE_CLKS(CYC)) uut (.clk_sys(clk_sys), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .refFault(refFault),
		.inactivityAlarm(inactivityAlarm), .bucketCount(bucketCount));

	lbm_ref_source refSrc (.clk_sys(clk_sys), .rstn(rstn), .faultOn(faultOn),
		.glitch(glitch), .refFault(refFault));

	//----------------------------------------------------------------
	// Register access
	//----------------------------------------------------------------
	// Request held until pready is seen high at a rising edge
	task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'h0};
		pwdata  <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// A transfer that never completes is itself a mismatch
		if (n >= 50) begin
			fail_count++;
			$display("BAD %0t apb transfer timed out", $time);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic regWrite(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		logic        err;
		xfer(1'b1, idx, wd, rd, err);
		`CHK(err, 1'b0)
	endtask : regWrite

	task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp, input logic expErr);
		logic [31:0] rd;
		logic        err;
		xfer(1'b0, idx, 32'h0000_0000, rd, err);
		`CHK(rd, exp)
		`CHK(err, expErr)
	endtask : rdChk

	// Bounded wait for the accumulator to show a value
	task automatic waitCount(input lbm_pkg::lbm_byte_t v);
		int n;
		n = 0;
		while (bucketCount !== v && n < 40 * CYC) begin
			@(posedge clk_sys);
			n++;
		end
		#1;
		`CHK(bucketCount, v)
	endtask : waitCount

	task automatic close_out();
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	//----------------------------------------------------------------
	// Tests
	//----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		rdChk(lbm_pkg::IDX_LEAK_RATE, 32'h0000_0002, 1'b0);
		rdChk(lbm_pkg::IDX_RAISE_LEVEL, 32'h0000_0006, 1'b0);
		rdChk(lbm_pkg::IDX_CLEAR_LEVEL, 32'h0000_0004, 1'b0);
		rdChk(lbm_pkg::IDX_BUCKET_SIZE, 32'h0000_0008, 1'b0);
		rdChk(lbm_pkg::IDX_STATUS, 32'h0000_0000, 1'b0);
		rdChk(10'h070, 32'h0000_0000, 1'b1);
		regWrite(lbm_pkg::IDX_RAISE_LEVEL, 32'h0000_000a);
		rdChk(lbm_pkg::IDX_RAISE_LEVEL, 32'h0000_000a, 1'b0);
		regWrite(lbm_pkg::IDX_RAISE_LEVEL, 32'h0000_0006);
		regWrite(lbm_pkg::IDX_STATUS, 32'h0000_01ff);
		rdChk(lbm_pkg::IDX_STATUS, 32'h0000_0000, 1'b0);
		begin
			logic [31:0] rdv;
			logic        errv;
			xfer(1'b1, 10'h070, 32'h0000_00ff, rdv, errv);
			`CHK(errv, 1'b1)
		end
		regWrite(lbm_pkg::IDX_LEAK_RATE, 32'hffff_fffc);
		rdChk(lbm_pkg::IDX_LEAK_RATE, 32'h0000_0000, 1'b0);
		faultOn <= 1'b1;
		waitCount(8'h05);
		`CHK(inactivityAlarm, 1'b0)
		waitCount(8'h06);
		`CHK(inactivityAlarm, 1'b1)
		waitCount(8'h08);
		repeat (3 * CYC) @(posedge clk_sys);
		`CHK(bucketCount, 8'h08)
		rdChk(lbm_pkg::IDX_STATUS, 32'h0000_0108, 1'b0);
		faultOn <= 1'b0;
		waitCount(8'h05);
		`CHK(inactivityAlarm, 1'b1)
		waitCount(8'h04);
		`CHK(inactivityAlarm, 1'b0)
		waitCount(8'h00);
		repeat (3 * CYC) @(posedge clk_sys);
		`CHK(bucketCount, 8'h00)
		// Each rate code: one erratic burst, then time the leak back to zero
		for (int r = 0; r < 4; r++) begin
			regWrite(lbm_pkg::IDX_LEAK_RATE, 32'(r));
			@(posedge clk_sys);
			glitch <= 1'b1;
			@(posedge clk_sys);
			glitch <= 1'b0;
			waitCount(8'h01);
			k = 0;
			while (bucketCount !== 8'h00 && k < 40 * CYC) begin
				@(posedge clk_sys);
				k++;
			end
			`CHK(k == (CYC << r), 1'b1)
		end
		close_out();
	end

	// Whole run is well under a thousand monitor clocks
	initial begin
		#50us;
		fail_count++;
		close_out();
	end
endmodule : tb
